// ==== jdrc_top.sv ====
// instruction register and data register chains of the test access port
// Behaviour
// - sample instruction selects boundary chain
// - capture pad input, output, enable
// - shift samples out while preload enters
// - update copies shifted bits to parallel
// - preload forces pads or core inputs
// - abort instruction selects abort chain
// - abort chain is 35 bits
// - debug port access chain, 35 bits
// - access port access chain, 35 bits
// - identification loaded on resets, logic reset
// - 32-bit fixed identification chain
// - identification value lsb is one
// - bypass is a single shift stage
// - bypass captures zero
// - three cells per pin, in order
// - reset pin has input cell only
// - exactly six data chains
// - four-bit instruction decode
// - unknown codes act as bypass
`timescale 1ns/1ps
module jdrc_top
  import jdrc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // test port pins
  input wire logic tck,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  // tap state flags from the tap controller
  input wire logic tap_reset,
  input wire logic tap_capture_ir,
  input wire logic tap_shift_ir,
  input wire logic tap_update_ir,
  input wire logic tap_capture_dr,
  input wire logic tap_shift_dr,
  input wire logic tap_update_dr,
  // pads and core
  input wire logic [GPIO_NUM-1:0] pad_in,
  input wire logic ext_rst_pin,
  input wire logic [GPIO_NUM-1:0] core_out,
  input wire logic [GPIO_NUM-1:0] core_oe,
  output logic [GPIO_NUM-1:0] pad_out,
  output logic [GPIO_NUM-1:0] pad_oe,
  output logic [GPIO_NUM-1:0] core_in,
  // debug access port side
  input wire logic [DBG_W-1:0] dp_capture,
  input wire logic [DBG_W-1:0] ap_capture,
  output logic [DBG_W-1:0] abort_word,
  output logic abort_strobe,
  output logic [DBG_W-1:0] dp_word,
  output logic dp_strobe,
  output logic [DBG_W-1:0] ap_word,
  output logic ap_strobe,
  // current instruction
  output logic [IR_W-1:0] instr
);

  // -------------------------------------------------------------
  // reset release and pin synchronisers
  // -------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [GPIO_NUM:0] pad_s1;
  logic [GPIO_NUM:0] pad_s2;
  logic tck_d;
  logic tck_s;
  logic tdi_s;
  logic trst_s_n;
  logic tck_rise;
  logic tck_fall;

  // reset asserts at once, releases after two clocks
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // pins and pads pass two flops; edge flop reads only the second
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 4'h4;
      pin_s2 <= 4'h4;
      pad_s1 <= '0;
      pad_s2 <= '0;
      tck_d <= 1'b0;
    end
    else
    begin
      pin_s1 <= {1'b0, trst_n, tdi, tck};
      pin_s2 <= pin_s1;
      pad_s1 <= {ext_rst_pin, pad_in};
      pad_s2 <= pad_s1;
      tck_d <= tck_s;
    end
  end
  // synchronised pin levels and tck edges
  assign tck_s = pin_s2[0];
  assign tdi_s = pin_s2[1];
  assign trst_s_n = pin_s2[2];
  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;
  // -------------------------------------------------------------
  // instruction register
  // -------------------------------------------------------------
  logic [IR_W-1:0] ir_sr;
  logic [IR_W-1:0] ir_r;
  // ir shift stage
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ir_sr <= IR_CAPTURE_VAL;
    else if (tck_rise && tap_capture_ir)
      ir_sr <= IR_CAPTURE_VAL;
    else if (tck_rise && tap_shift_ir)
      ir_sr <= {tdi_s, ir_sr[IR_W-1:1]};
  end
  // current instruction; identification after any reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ir_r <= IR_IDENT;
    else if (!trst_s_n || tap_reset)
      ir_r <= IR_IDENT;
    else if (tck_fall && tap_update_ir)
      ir_r <= ir_sr;
  end

  assign instr = ir_r;

  // -------------------------------------------------------------
  // instruction decode
  // -------------------------------------------------------------
  logic sel_bsc;
  logic sel_id;
  logic sel_abort;
  logic sel_dp;
  logic sel_ap;
  logic sel_byp;
  logic extest;
  logic intest;
  // four-bit decode, unassigned codes fall to bypass
  assign sel_bsc = (ir_r == IR_SAMPLE);
  assign sel_abort = (ir_r == IR_ABORT);
  assign sel_dp = (ir_r == IR_DP_ACCESS);
  assign sel_ap = (ir_r == IR_AP_ACCESS);
  assign sel_id = (ir_r == IR_IDENT);
  assign sel_byp = ~(sel_bsc | sel_abort | sel_dp | sel_ap | sel_id);
  // test instructions have no chain of their own, so bypass serves
  assign extest = (ir_r == IR_EXTEST);
  assign intest = (ir_r == IR_INTEST);
  // -------------------------------------------------------------
  // the six data chains
  // -------------------------------------------------------------
  logic cap_ev;
  logic shf_ev;
  logic upd_ev;
  logic [BSC_W-1:0] bsc_cap;
  assign cap_ev = tck_rise & tap_capture_dr;
  assign shf_ev = tck_rise & tap_shift_dr;
  assign upd_ev = tck_fall & tap_update_dr;
  jdrc_chain_if #(.W(BSC_W)) bsc_if ();
  jdrc_chain_if #(.W(ID_W)) id_if ();
  jdrc_chain_if #(.W(BYP_W)) byp_if ();
  jdrc_chain_if #(.W(DBG_W)) abort_if ();
  jdrc_chain_if #(.W(DBG_W)) dp_if ();
  jdrc_chain_if #(.W(DBG_W)) ap_if ();

  // boundary chain steering
  assign bsc_if.capture = cap_ev & sel_bsc;
  assign bsc_if.shift = shf_ev & sel_bsc;
  assign bsc_if.update = upd_ev & sel_bsc;
  assign bsc_if.tdi = tdi_s;
  assign bsc_if.cap_val = bsc_cap;

  // identification chain steering
  assign id_if.capture = cap_ev & sel_id;
  assign id_if.shift = shf_ev & sel_id;
  assign id_if.update = 1'b0;
  assign id_if.tdi = tdi_s;
  assign id_if.cap_val = {ID_VALUE[ID_W-1:1], 1'b1};

  // bypass chain steering
  assign byp_if.capture = cap_ev & sel_byp;
  assign byp_if.shift = shf_ev & sel_byp;
  assign byp_if.update = 1'b0;
  assign byp_if.tdi = tdi_s;
  assign byp_if.cap_val = BYP_CAPTURE;

  // abort chain steering
  assign abort_if.capture = cap_ev & sel_abort;
  assign abort_if.shift = shf_ev & sel_abort;
  assign abort_if.update = upd_ev & sel_abort;
  assign abort_if.tdi = tdi_s;
  assign abort_if.cap_val = '0;

  // debug port access chain steering
  assign dp_if.capture = cap_ev & sel_dp;
  assign dp_if.shift = shf_ev & sel_dp;
  assign dp_if.update = upd_ev & sel_dp;
  assign dp_if.tdi = tdi_s;
  assign dp_if.cap_val = dp_capture;

  // access port access chain steering
  assign ap_if.capture = cap_ev & sel_ap;
  assign ap_if.shift = shf_ev & sel_ap;
  assign ap_if.update = upd_ev & sel_ap;
  assign ap_if.tdi = tdi_s;
  assign ap_if.cap_val = ap_capture;

  // six instances of the chain, no more
  jdrc_chain #(.W(BSC_W)) u_bsc (.clock(clock), .rst_n(rst_n), .bus(bsc_if.chain));
  jdrc_chain #(.W(ID_W)) u_id (.clock(clock), .rst_n(rst_n), .bus(id_if.chain));
  jdrc_chain #(.W(BYP_W)) u_byp (.clock(clock), .rst_n(rst_n), .bus(byp_if.chain));
  jdrc_chain #(.W(DBG_W)) u_abort (.clock(clock), .rst_n(rst_n), .bus(abort_if.chain));
  jdrc_chain #(.W(DBG_W)) u_dp (.clock(clock), .rst_n(rst_n), .bus(dp_if.chain));
  jdrc_chain #(.W(DBG_W)) u_ap (.clock(clock), .rst_n(rst_n), .bus(ap_if.chain));
  // -------------------------------------------------------------
  // boundary cells and pad forcing
  // -------------------------------------------------------------
  logic [GPIO_NUM-1:0] pre_in;
  logic [GPIO_NUM-1:0] pre_out;
  logic [GPIO_NUM-1:0] pre_oe;
  // per pin: input, output, enable; pins in chain order from the port
  genvar gi;
  generate
    for (gi = 0; gi < GPIO_NUM; gi++)
    begin : g_cell
      assign bsc_cap[gi*CELLS_PER_PIN+CELL_IN] = pad_s2[gi];
      assign bsc_cap[gi*CELLS_PER_PIN+CELL_OUT] = pad_out[gi];
      assign bsc_cap[gi*CELLS_PER_PIN+CELL_OE] = pad_oe[gi];
      assign pre_in[gi] = bsc_if.par[gi*CELLS_PER_PIN+CELL_IN];
      assign pre_out[gi] = bsc_if.par[gi*CELLS_PER_PIN+CELL_OUT];
      assign pre_oe[gi] = bsc_if.par[gi*CELLS_PER_PIN+CELL_OE];
    end
  endgenerate

  // reset pin is observe only, one input cell
  assign bsc_cap[CELL_RST] = pad_s2[GPIO_NUM];
  // pads take preload under external test
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out <= '0;
      pad_oe <= '0;
    end
    else if (extest)
    begin
      pad_out <= pre_out;
      pad_oe <= pre_oe;
    end
    else
    begin
      pad_out <= core_out;
      pad_oe <= core_oe;
    end
  end
  // core inputs take preload under internal test
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      core_in <= '0;
    else if (intest)
      core_in <= pre_in;
    else
      core_in <= pad_s2[GPIO_NUM-1:0];
  end
  // -------------------------------------------------------------
  // debug port words and strobes
  // -------------------------------------------------------------
  assign abort_word = abort_if.par;
  assign dp_word = dp_if.par;
  assign ap_word = ap_if.par;

  // one-cycle strobe once a new word has landed
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      abort_strobe <= 1'b0;
      dp_strobe <= 1'b0;
      ap_strobe <= 1'b0;
    end
    else
    begin
      abort_strobe <= abort_if.update;
      dp_strobe <= dp_if.update;
      ap_strobe <= ap_if.update;
    end
  end

  // -------------------------------------------------------------
  // serial output
  // -------------------------------------------------------------
  logic tdo_nxt;
  // lsb of the selected path
  assign tdo_nxt = tap_shift_ir ? ir_sr[0] : sel_bsc ? bsc_if.sr[0] :
    sel_id ? id_if.sr[0] : sel_abort ? abort_if.sr[0] : sel_dp ? dp_if.sr[0] :
    sel_ap ? ap_if.sr[0] : byp_if.sr[0];
  // tdo changes on the falling tck edge, driven only while shifting
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo <= tdo_nxt;
      tdo_oe <= tap_shift_ir | tap_shift_dr;
    end
  end

endmodule

// ==== jdrc_pkg.sv ====
// constants shared by the test data register chains
package jdrc_pkg;
  // instruction register
  localparam int IR_W = 4;
  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_INTEST = 4'h1;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_ABORT = 4'h8;
  localparam logic [3:0] IR_DP_ACCESS = 4'hA;
  localparam logic [3:0] IR_AP_ACCESS = 4'hB;
  localparam logic [3:0] IR_IDENT = 4'hE;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;
  // chain lengths
  localparam int ID_W = 32;
  localparam int DBG_W = 35;
  localparam int BYP_W = 1;
  localparam int GPIO_NUM = 8;
  localparam int CELLS_PER_PIN = 3;
  localparam int BSC_W = GPIO_NUM * CELLS_PER_PIN + 1;
  // cell positions within one pin group, and the reset pin cell at the chain end
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;
  localparam int CELL_RST = BSC_W - 1;
  // capture values; identity value is arbitrary, bit 0 must stay 1
  localparam logic [31:0] ID_VALUE = 32'h0F0F_5A01;
  localparam logic [0:0] BYP_CAPTURE = 1'h0;
endpackage

// ==== jdrc_chain_if.sv ====
// carrier between the chain controller and one serial data chain
`timescale 1ns/1ps
interface jdrc_chain_if #(parameter int W = 1);
  logic capture;
  logic shift;
  logic update;
  logic tdi;
  logic [W-1:0] cap_val;
  logic [W-1:0] sr;
  logic [W-1:0] par;
  modport ctl (output capture, shift, update, tdi, cap_val, input sr, par);
  modport chain (input capture, shift, update, tdi, cap_val, output sr, par);
endinterface

// ==== jdrc_chain.sv ====
// one serial data chain with its parallel update register
`timescale 1ns/1ps
module jdrc_chain
  import jdrc_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // controller side
  jdrc_chain_if.chain bus
);

  // -------------------------------------------------------------
  // shift stage
  // -------------------------------------------------------------
  generate
    if (W == 1)
    begin : g_one
      // single stage shifts straight from tdi
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          bus.sr <= '0;
        else if (bus.capture)
          bus.sr <= bus.cap_val;
        else if (bus.shift)
          bus.sr <= bus.tdi;
      end
    end
    else
    begin : g_many
      // lsb leaves first, tdi enters at the top
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          bus.sr <= '0;
        else if (bus.capture)
          bus.sr <= bus.cap_val;
        else if (bus.shift)
          bus.sr <= {bus.tdi, bus.sr[W-1:1]};
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // parallel update register
  // -------------------------------------------------------------
  // holds the shifted word once the update state is reached
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      bus.par <= '0;
    else if (bus.update)
      bus.par <= bus.sr;
  end

endmodule

// ==== jdrc_top_sva.sv ====
// assertion checker for the test data register chains
`timescale 1ns/1ps
module jdrc_top_sva
  import jdrc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // test port and tap states
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tap_reset,
  input wire logic tap_shift_ir,
  input wire logic tap_shift_dr,
  // pads and core
  input wire logic [GPIO_NUM-1:0] pad_in,
  input wire logic [GPIO_NUM-1:0] core_out,
  input wire logic [GPIO_NUM-1:0] core_oe,
  input wire logic [GPIO_NUM-1:0] pad_out,
  input wire logic [GPIO_NUM-1:0] pad_oe,
  input wire logic [GPIO_NUM-1:0] core_in,
  // debug port side
  input wire logic [DBG_W-1:0] abort_word,
  input wire logic abort_strobe,
  input wire logic [DBG_W-1:0] dp_word,
  input wire logic dp_strobe,
  input wire logic [DBG_W-1:0] ap_word,
  input wire logic ap_strobe,
  input wire logic [IR_W-1:0] instr
);
  // ----------------------------
  // settle counter after reset
  // ----------------------------
  logic [2:0] up_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // saturating count, hides synchroniser fill
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      up_r <= 3'h0;
    else if (up_r != 3'h7)
      up_r <= up_r + 3'h1;
  end
  // ----------------------------
  // properties
  // ----------------------------
  property p_tlr_ident;
    tap_reset |=> instr == IR_IDENT;
  endproperty
  a_tlr_ident: assert property (p_tlr_ident) else $error("instr not ident after logic reset");
  property p_trst_ident;
    !trst_n [*3] |=> instr == IR_IDENT;
  endproperty
  a_trst_ident: assert property (p_trst_ident) else $error("instr not ident after trst");
  property p_pad_core;
    (up_r == 3'h7 && instr != IR_EXTEST && $stable(core_out) && $stable(core_oe)) [*2]
      |-> pad_out == core_out && pad_oe == core_oe;
  endproperty
  a_pad_core: assert property (p_pad_core) else $error("pads not driven by core");
  property p_core_pad;
    (up_r == 3'h7 && instr != IR_INTEST && $stable(pad_in)) [*4] |-> core_in == pad_in;
  endproperty
  a_core_pad: assert property (p_core_pad) else $error("core inputs not from pads");
  property p_abort_pulse;
    !$stable(abort_word) |-> abort_strobe ##1 !abort_strobe;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort strobe not one pulse");
  property p_dp_strobe;
    !$stable(dp_word) |-> dp_strobe ##1 !dp_strobe;
  endproperty
  a_dp_strobe: assert property (p_dp_strobe) else $error("dp strobe not one pulse");
  property p_ap_strobe;
    !$stable(ap_word) |-> ap_strobe ##1 !ap_strobe;
  endproperty
  a_ap_strobe: assert property (p_ap_strobe) else $error("ap strobe not one pulse");
  property p_oe_shift;
    $rose(tdo_oe) |-> tap_shift_dr || tap_shift_ir;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("tdo enabled outside shift");
  property p_tdo_fall;
    up_r == 3'h7 && $changed(tdo) |-> !$past(tck, 2);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
endmodule

bind jdrc_top jdrc_top_sva chk_u (.clock, .rstn, .tck, .trst_n, .tdo, .tdo_oe, .tap_reset,
  .tap_shift_ir, .tap_shift_dr, .pad_in, .core_out, .core_oe, .pad_out, .pad_oe, .core_in,
  .abort_word, .abort_strobe, .dp_word, .dp_strobe, .ap_word, .ap_strobe, .instr);

// ==== jdrc_tester.sv ====
// tester model driving the test port pins and tap state levels
`timescale 1ns/1ps
module jdrc_tester
  import jdrc_pkg::*;
(
  // clock
  input wire logic clock,
  // test port
  output logic tck,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  // tap states: reset, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, upd_dr
  output logic [6:0] st
);
  // idle pins, tck stands still
  initial
  begin
    tck = 1'h0;
    tdi = 1'h0;
    trst_n = 1'h1;
    st = 7'h00;
  end
  // one tck period: fall, sample tdo late in low phase, rise
  task automatic cyc(input int s, input logic b, output logic q);
    @(posedge clock);
    st <= (s < 0) ? 7'h00 : 7'(1 << s);
    tdi <= b;
    tck <= 1'h0;
    repeat (8) @(posedge clock);
    q = tdo;
    tck <= 1'h1;
    repeat (7) @(posedge clock);
  endtask
  // capture, shift n bits lsb first, exit, update; unused tdi toggles
  task automatic scan(input bit ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    dout = 64'h0;
    cyc(ir ? 1 : 4, ~tdi, q);
    for (int i = 0; i < n; i++)
    begin
      cyc(ir ? 2 : 5, din[i], q);
      dout[i] = q;
    end
    cyc(-1, ~tdi, q);
    cyc(ir ? 3 : 6, ~tdi, q);
    cyc(-1, ~tdi, q);
  endtask
  // reset through the pin or through the logic reset state
  task automatic reset_port(input bit pin);
    logic q;
    trst_n <= !pin;
    cyc(pin ? -1 : 0, ~tdi, q);
    trst_n <= 1'h1;
    cyc(-1, ~tdi, q);
  endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the test data register chains
`timescale 1ns/1ps
module testbench;
  import jdrc_pkg::*;
  typedef struct packed {logic [3:0] code; logic [7:0] len; logic [63:0] cap;} jdrc_row_t;
  // ----------------------------
  // signals
  // ----------------------------
  logic clock, rstn, tck, tdi, trst_n, tdo, tdo_oe, ext_rst_pin;
  logic [6:0] st;
  logic [GPIO_NUM-1:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in;
  logic [DBG_W-1:0] dp_capture, ap_capture, abort_word, dp_word, ap_word;
  logic abort_strobe, dp_strobe, ap_strobe;
  logic [IR_W-1:0] instr;
  int err_count = 0;
  int tests_run = 0;
  jdrc_row_t rows [10];
`define CHK(name, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("unexpected %s exp %h got %h", name, exp, got); \
    end \
  end
  // ----------------------------
  // instances
  // ----------------------------
  jdrc_top dut_u (.clock(clock), .rstn(rstn), .tck(tck), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .tap_reset(st[0]), .tap_capture_ir(st[1]),
    .tap_shift_ir(st[2]), .tap_update_ir(st[3]), .tap_capture_dr(st[4]),
    .tap_shift_dr(st[5]), .tap_update_dr(st[6]), .pad_in(pad_in), .ext_rst_pin(ext_rst_pin),
    .core_out(core_out), .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe),
    .core_in(core_in), .dp_capture(dp_capture), .ap_capture(ap_capture),
    .abort_word(abort_word), .abort_strobe(abort_strobe), .dp_word(dp_word),
    .dp_strobe(dp_strobe), .ap_word(ap_word), .ap_strobe(ap_strobe), .instr(instr));
  jdrc_tester tester_u (.clock(clock), .tck(tck), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .st(st));
  // clock and run limit
  always #2 clock = ~clock;
  initial
  begin
    repeat (90000) @(posedge clock);
    err_count++;
    print_verdict();
  end
  // ----------------------------
  // tasks
  // ----------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic load(input logic [3:0] code);
    logic [63:0] q;
    tester_u.scan(1'b1, IR_W, 64'(code), q);
  endtask
  // boundary capture: input, output, enable per pin, reset pin last
  function automatic logic [BSC_W-1:0] bsc_exp();
    logic [BSC_W-1:0] v;
    for (int k = 0; k < GPIO_NUM; k++)
      v[3*k +: 3] = {core_oe[k], core_out[k], pad_in[k]};
    v[BSC_W-1] = ext_rst_pin;
    return v;
  endfunction
  // ----------------------------
  // main sequence
  // ----------------------------
  initial
  begin
    logic [63:0] din, q, exp_v;
    logic [BSC_W-1:0] pre;
    clock = 1'h0;
    rstn = 1'h0;
    pad_in = 8'hA5;
    ext_rst_pin = 1'h1;
    core_out = 8'h3C;
    core_oe = 8'hF0;
    dp_capture = 35'h5_1234_5678;
    ap_capture = 35'h2_8765_4321;
    repeat (10) @(posedge clock);
    `CHK("reset instr", IR_IDENT, instr);
    `CHK("reset tdo_oe", 1'h0, tdo_oe);
    rstn <= 1'h1;
    repeat (10) @(posedge clock);
    $display("test reset done");
    rows[0] = '{IR_IDENT, 8'd32, {32'h0, ID_VALUE}};
    rows[1] = '{IR_BYPASS, 8'd1, 64'h0};
    rows[2] = '{IR_ABORT, 8'd35, 64'h0};
    rows[3] = '{IR_DP_ACCESS, 8'd35, 64'(dp_capture)};
    rows[4] = '{IR_AP_ACCESS, 8'd35, 64'(ap_capture)};
    rows[5] = '{IR_SAMPLE, 8'(BSC_W), 64'(bsc_exp())};
    rows[6] = '{4'h5, 8'd1, 64'h0};
    rows[7] = '{4'hC, 8'd1, 64'h0};
    rows[8] = '{IR_EXTEST, 8'd1, 64'h0};
    rows[9] = '{IR_INTEST, 8'd1, 64'h0};
    // each code: ir capture, chain length, capture value; update word for abort, dp and ap codes
    foreach (rows[i])
    begin
      tester_u.scan(1'b1, IR_W, 64'(rows[i].code), q);
      `CHK("ir capture", 64'(IR_CAPTURE_VAL), q);
      `CHK("instr", rows[i].code, instr);
      din = 64'hC3A5_96F0_0F69_5A3C ^ 64'(i * 7);
      tester_u.scan(1'b0, rows[i].len + 8, din, q);
      exp_v = (din << rows[i].len) | rows[i].cap;
      exp_v &= (64'h1 << (rows[i].len + 8)) - 64'h1;
      `CHK("dr out", exp_v, q);
      if (rows[i].code == IR_IDENT)
        `CHK("id lsb", 1'h1, q[0])
      if (rows[i].code == IR_ABORT)
        `CHK("abort word", din[rows[i].len + 7 -: DBG_W], abort_word)
      if (rows[i].code == IR_DP_ACCESS)
        `CHK("dp word", din[rows[i].len + 7 -: DBG_W], dp_word)
      if (rows[i].code == IR_AP_ACCESS)
        `CHK("ap word", din[rows[i].len + 7 -: DBG_W], ap_word)
      $display("test code %h done", rows[i].code);
    end
    // preload, then force pads and core inputs from it
    pre = 25'h1_2D_B4C3;
    load(IR_SAMPLE);
    tester_u.scan(1'b0, BSC_W, 64'(pre), q);
    load(IR_EXTEST);
    for (int k = 0; k < GPIO_NUM; k++)
    begin
      `CHK("pad_out", pre[3*k+1], pad_out[k]);
      `CHK("pad_oe", pre[3*k+2], pad_oe[k]);
    end
    load(IR_INTEST);
    for (int k = 0; k < GPIO_NUM; k++)
      `CHK("core_in", pre[3*k], core_in[k]);
    core_out <= 8'h96;
    pad_in <= 8'h4B;
    load(IR_BYPASS);
    `CHK("pad_out core", 8'h96, pad_out);
    `CHK("core_in pad", 8'h4B, core_in);
    $display("test preload done");
    // logic reset state and reset pin both restore ident
    tester_u.reset_port(1'b0);
    `CHK("tlr instr", IR_IDENT, instr);
    load(IR_BYPASS);
    tester_u.reset_port(1'b1);
    `CHK("trst instr", IR_IDENT, instr);
    $display("test port reset done");
    print_verdict();
  end
endmodule
